// [mcrs_pkg.sv]
// Register map, field positions and constants for the MAC config and receive statistics block
package mcrs_pkg;
  // Register base byte addresses, each with set/clear/invert aliases at +4/+8/+C
  localparam logic [7:0] MCRS_OFS_RX_OK = 8'h00;
  localparam logic [7:0] MCRS_OFS_FCS = 8'h10;
  localparam logic [7:0] MCRS_OFS_ALIGN = 8'h20;
  localparam logic [7:0] MCRS_OFS_CFG1 = 8'h30;
  localparam logic [7:0] MCRS_OFS_CFG2 = 8'h40;
  localparam logic [1:0] MCRS_ALIAS_PLAIN = 2'h0;
  localparam logic [1:0] MCRS_ALIAS_SET = 2'h1;
  localparam logic [1:0] MCRS_ALIAS_CLR = 2'h2;
  localparam logic [1:0] MCRS_ALIAS_INV = 2'h3;
  // Write lane patterns; LO and ALL are accepted, HI is not
  localparam logic [3:0] MCRS_LANES_LO = 4'h3;
  localparam logic [3:0] MCRS_LANES_HI = 4'hC;
  localparam logic [3:0] MCRS_LANES_ALL = 4'hF;
  // Reset values and writable masks
  localparam logic [15:0] MCRS_CFG1_RESET = 16'h800D;
  localparam logic [15:0] MCRS_CFG1_MASK = 16'hCF1F;
  localparam logic [15:0] MCRS_CFG2_RESET = 16'h40B0;
  localparam logic [15:0] MCRS_CFG2_MASK = 16'h73F0;
  localparam logic [15:0] MCRS_CNT_MASK = 16'hFFFF;
  // First configuration register fields
  localparam int MCRS_B_WHOLE_MAC_RESET = 15;
  localparam int MCRS_B_BACKOFF_RNG_RESET = 14;
  localparam int MCRS_B_RX_CTRL_SUBLAYER_RESET = 11;
  localparam int MCRS_B_RX_FUNCTION_RESET = 10;
  localparam int MCRS_B_TX_CTRL_SUBLAYER_RESET = 9;
  localparam int MCRS_B_TX_FUNCTION_RESET = 8;
  localparam int MCRS_B_LOOPBACK = 4;
  localparam int MCRS_B_TX_FLOW_FRAME_ALLOW = 3;
  localparam int MCRS_B_RX_FLOW_FRAME_HONOR = 2;
  localparam int MCRS_B_ACCEPT_EVERY_FRAME = 1;
  localparam int MCRS_B_RX_FRAME_ENABLE = 0;
  // Second configuration register fields
  localparam int MCRS_B_UNBOUNDED_DEFER = 14;
  localparam int MCRS_B_BACKPRESSURE_SKIP_BACKOFF = 13;
  localparam int MCRS_B_SKIP_BACKOFF = 12;
  localparam int MCRS_B_PREAMBLE_LENGTH_LIMIT = 9;
  localparam int MCRS_B_PREAMBLE_CONTENT_CHECK = 8;
  localparam int MCRS_B_TAG_DETECT_PAD = 7;
  localparam int MCRS_B_PAD_TO_SIXTY_FOUR = 6;
  localparam int MCRS_B_SHORT_FRAME_PAD_ON = 5;
  localparam int MCRS_B_CRC_APPEND_ON = 4;
  // Frame constants
  localparam logic [6:0] MCRS_PAD_NONE = 7'h00;
  localparam logic [6:0] MCRS_PAD_SHORT = 7'h3C;
  localparam logic [6:0] MCRS_PAD_LONG = 7'h40;
  localparam logic [15:0] MCRS_VLAN_TPID = 16'h8100;
  localparam logic [4:0] MCRS_PREAMBLE_MAX = 5'h0C;
  localparam logic [4:0] MCRS_PREAMBLE_SAT = 5'h1F;
  localparam logic [7:0] MCRS_PREAMBLE_BYTE = 8'h55;
  localparam logic [9:0] MCRS_RNG_SEED = 10'h001;
  localparam logic [9:0] MCRS_RNG_TAPS = 10'h240;
  // Register select codes
  typedef enum logic [2:0] {
    MCRS_SEL_NONE,
    MCRS_SEL_RX_OK,
    MCRS_SEL_FCS,
    MCRS_SEL_ALIGN,
    MCRS_SEL_CFG1,
    MCRS_SEL_CFG2
  } mcrs_sel_t;
endpackage

// [mcrs_mac_config_and_rx_error_stats.sv]
// MAC configuration registers and receive error statistics counters behind an APB slave
//
// Summary of operation
// R1 - Count frames accepted by the receive filter, except those with FCS or alignment error.
// R2 - Count frames with FCS error whose bit length is a whole number of bytes.
// R3 - Count frames with FCS error and a dribble nibble as alignment errors.
// R4 - A counter read clears it, unless byte lanes 0 and 1 are both off.
// R5 - Counters are 16 bits in the low half; bits 31 to 16 read zero.
// R6 - Software edits counters through aliases; direct writes are for debug only.
// R7 - Soft reset holds all MAC and media logic in reset; resets to one.
// R8 - Simulation reset restarts the transmit backoff random number generator.
// R9 - Four bits hold receive/transmit control sublayer and function logic in reset.
// R10 - Loopback routes transmit interface back into receive; clear means normal.
// R11 - Pause frames: transmit allowed when set; received ones acted on when set. Acted on only when accepted, so control ones need pass-all.
// R12 - Pass-all accepts control frames too; clear ignores received control frames.
// R13 - Frames are received only while receive enable is one; it resets to one.
// R14 - Configuration accepts low-half 16-bit and 32-bit accesses and aliases; 8-bit and upper-half ones ignored.
// R15 - Unbounded defer waits for carrier forever; clear aborts at deferral limit.
// R16 - Skip backoff after any collision, or after own backpressure collisions.
// R17 - Length limit rejects received preambles of 12 bytes or more.
// R18 - Content check discards packets whose preamble bytes are not clean 0x55.
// R19 - Tag detect compares type octets with 0x8100 to choose padding.
// R20 - Sixty-four pad pads short frames to 64 with CRC; needs pad enable.
// R21 - Pad enable pads short frames; clear means frames already have valid length.
// R22 - CRC enable appends CRC to every frame; clear means frames carry CRC.
// R23 - Plain padding, or untagged under tag detect, pads to 60 with CRC.
// R24 - Increment during a clearing read returns old value and keeps new event.
`timescale 1ns/1ns
`default_nettype none
module mcrs_mac_config_and_rx_error_stats
  import mcrs_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Receive preamble byte stream
  input wire logic i_rx_pre_valid,
  input wire logic [7:0] i_rx_pre_byte,
  input wire logic i_rx_pre_err,
  // Receive frame end status
  input wire logic i_rx_frame_end,
  input wire logic i_rx_filter_ok,
  input wire logic i_rx_fcs_err,
  input wire logic i_rx_dribble,
  input wire logic i_rx_is_control,
  input wire logic i_rx_is_pause,
  // Transmit frame type field
  input wire logic i_tx_type_valid,
  input wire logic [15:0] i_tx_type_field,
  // Receive side results
  output logic o_rx_frame_accept,
  output logic o_rx_pause_act,
  // Transmit pad and CRC decision
  output logic [6:0] o_tx_pad_len,
  output logic o_tx_crc_append,
  // Reset controls to the MAC
  output logic o_media_if_reset,
  output logic o_rx_ctrl_reset,
  output logic o_rx_func_reset,
  output logic o_tx_ctrl_reset,
  output logic o_tx_func_reset,
  // Mode controls to the MAC
  output logic o_loopback,
  output logic o_tx_pause_allow,
  output logic o_unbounded_defer,
  output logic o_skip_backoff,
  output logic o_bp_skip_backoff,
  output logic [9:0] o_backoff_rand
);

  function automatic mcrs_sel_t mcrs_decode(input logic [7:0] addr);
    if (addr[7:4] == MCRS_OFS_RX_OK[7:4]) begin
      return MCRS_SEL_RX_OK;
    end else if (addr[7:4] == MCRS_OFS_FCS[7:4]) begin
      return MCRS_SEL_FCS;
    end else if (addr[7:4] == MCRS_OFS_ALIGN[7:4]) begin
      return MCRS_SEL_ALIGN;
    end else if (addr[7:4] == MCRS_OFS_CFG1[7:4]) begin
      return MCRS_SEL_CFG1;
    end else if (addr[7:4] == MCRS_OFS_CFG2[7:4]) begin
      return MCRS_SEL_CFG2;
    end else begin
      return MCRS_SEL_NONE;
    end
  endfunction

  // Applies plain, set, clear or invert write to the writable bits
  function automatic logic [15:0] mcrs_apply(input logic [15:0] old, input logic [15:0] wd,
                                             input logic [1:0] alias_sel,
                                             input logic [15:0] mask);
    logic [15:0] nv;
    nv = old;
    case (alias_sel)
      MCRS_ALIAS_PLAIN: nv = wd;
      MCRS_ALIAS_SET: nv = old | wd;
      MCRS_ALIAS_CLR: nv = old & ~wd;
      default: nv = old ^ wd;
    endcase
    return (nv & mask) | (old & ~mask);
  endfunction

  // Bus phase
  mcrs_sel_t sel;
  logic setup;
  logic done;
  logic wr_done;
  logic rd_done;
  logic lanes_ok;
  logic [15:0] wd_lo;
  logic [1:0] alias_sel;
  logic rd_clear;
  logic [15:0] rd_snap_q;

  // Registers
  logic [15:0] cnt_ok_q;
  logic [15:0] cnt_fcs_q;
  logic [15:0] cnt_align_q;
  logic [15:0] cfg1_q;
  logic [15:0] cfg2_q;

  // Receive status
  logic [4:0] pre_len_q;
  logic pre_bad_q;
  logic rx_held;
  logic pre_fail;
  logic rx_ok_evt;
  logic fcs_evt;
  logic align_evt;
  logic [15:0] cnt_read;
  logic tx_held;
  logic pad_on;

  assign sel = mcrs_decode(i_paddr);
  assign alias_sel = i_paddr[3:2];
  assign setup = i_psel & ~i_penable & ~o_pready;
  assign done = i_psel & i_penable & o_pready;
  assign wr_done = done & i_pwrite & ~o_pslverr;
  assign rd_done = done & ~i_pwrite & ~o_pslverr;
  // 8-bit and odd lane patterns are dropped  (see R14)
  assign lanes_ok = (i_pstrb == MCRS_LANES_LO) | (i_pstrb == MCRS_LANES_ALL);
  assign wd_lo = i_pwdata[15:0];
  // Reads with lanes 0 and 1 both off leave the counter alone  (see R4)
  assign rd_clear = rd_done & (i_pstrb[1:0] != 2'h0);

  always_comb begin
    case (sel)
      MCRS_SEL_RX_OK: cnt_read = cnt_ok_q;
      MCRS_SEL_FCS: cnt_read = cnt_fcs_q;
      MCRS_SEL_ALIGN: cnt_read = cnt_align_q;
      MCRS_SEL_CFG1: cnt_read = cfg1_q;
      MCRS_SEL_CFG2: cnt_read = cfg2_q;
      default: cnt_read = 16'h0000;
    endcase
  end

  // APB answer: data and ready are set up one edge after setup
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
      rd_snap_q <= 16'h0000;
    end else if (setup) begin
      o_pready <= 1'b1;
      o_pslverr <= (sel == MCRS_SEL_NONE);
      o_prdata <= {16'h0000, cnt_read}; // see R5
      rd_snap_q <= cnt_read;
    end else if (done) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end
  end

  // Receive side is held while any of its resets or soft reset is set
  assign rx_held = cfg1_q[MCRS_B_WHOLE_MAC_RESET] | cfg1_q[MCRS_B_RX_FUNCTION_RESET]
                   | cfg1_q[MCRS_B_RX_CTRL_SUBLAYER_RESET]; // see R7 see R9
  assign tx_held = cfg1_q[MCRS_B_WHOLE_MAC_RESET] | cfg1_q[MCRS_B_TX_FUNCTION_RESET];

  // Preamble length and content tracking
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      pre_len_q <= 5'h00;
      pre_bad_q <= 1'b0;
    end else if (rx_held | i_rx_frame_end) begin
      pre_len_q <= 5'h00;
      pre_bad_q <= 1'b0;
    end else if (i_rx_pre_valid) begin
      if (pre_len_q != MCRS_PREAMBLE_SAT) begin
        pre_len_q <= pre_len_q + 5'h01;
      end
      if (i_rx_pre_err | (i_rx_pre_byte != MCRS_PREAMBLE_BYTE)) begin
        pre_bad_q <= 1'b1; // see R18
      end
    end
  end

  assign pre_fail = (cfg2_q[MCRS_B_PREAMBLE_LENGTH_LIMIT] & (pre_len_q >= MCRS_PREAMBLE_MAX))
                    | (cfg2_q[MCRS_B_PREAMBLE_CONTENT_CHECK] & pre_bad_q); // see R17 see R18

  // Frame events only while receive is enabled and not held
  assign rx_ok_evt = i_rx_frame_end & ~rx_held & cfg1_q[MCRS_B_RX_FRAME_ENABLE]
                     & i_rx_filter_ok & ~i_rx_fcs_err & ~pre_fail
                     & (~i_rx_is_control | cfg1_q[MCRS_B_ACCEPT_EVERY_FRAME]); // see R1 see R12 see R13
  assign fcs_evt = i_rx_frame_end & ~rx_held & cfg1_q[MCRS_B_RX_FRAME_ENABLE]
                   & i_rx_fcs_err & ~i_rx_dribble; // see R2
  assign align_evt = i_rx_frame_end & ~rx_held & cfg1_q[MCRS_B_RX_FRAME_ENABLE]
                     & i_rx_fcs_err & i_rx_dribble; // see R3

  // Received OK counter
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_ok_q <= 16'h0000;
    end else if (wr_done & lanes_ok & (sel == MCRS_SEL_RX_OK)) begin
      cnt_ok_q <= mcrs_apply(cnt_ok_q, wd_lo, alias_sel, MCRS_CNT_MASK) + {15'h0000, rx_ok_evt};
    end else if (rd_clear & (sel == MCRS_SEL_RX_OK)) begin
      cnt_ok_q <= cnt_ok_q - rd_snap_q + {15'h0000, rx_ok_evt}; // see R4 see R24
    end else begin
      cnt_ok_q <= cnt_ok_q + {15'h0000, rx_ok_evt}; // see R1
    end
  end

  // FCS error counter
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_fcs_q <= 16'h0000;
    end else if (wr_done & lanes_ok & (sel == MCRS_SEL_FCS)) begin
      cnt_fcs_q <= mcrs_apply(cnt_fcs_q, wd_lo, alias_sel, MCRS_CNT_MASK) + {15'h0000, fcs_evt};
    end else if (rd_clear & (sel == MCRS_SEL_FCS)) begin
      cnt_fcs_q <= cnt_fcs_q - rd_snap_q + {15'h0000, fcs_evt}; // see R4 see R24
    end else begin
      cnt_fcs_q <= cnt_fcs_q + {15'h0000, fcs_evt}; // see R2
    end
  end

  // Alignment error counter
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_align_q <= 16'h0000;
    end else if (wr_done & lanes_ok & (sel == MCRS_SEL_ALIGN)) begin
      cnt_align_q <= mcrs_apply(cnt_align_q, wd_lo, alias_sel, MCRS_CNT_MASK)
                     + {15'h0000, align_evt};
    end else if (rd_clear & (sel == MCRS_SEL_ALIGN)) begin
      cnt_align_q <= cnt_align_q - rd_snap_q + {15'h0000, align_evt}; // see R4 see R24
    end else begin
      cnt_align_q <= cnt_align_q + {15'h0000, align_evt}; // see R3
    end
  end

  // First configuration register
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg1_q <= MCRS_CFG1_RESET; // see R7 see R13
    end else if (wr_done & lanes_ok & (sel == MCRS_SEL_CFG1)) begin
      cfg1_q <= mcrs_apply(cfg1_q, wd_lo, alias_sel, MCRS_CFG1_MASK); // see R14
    end
  end

  // Second configuration register
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg2_q <= MCRS_CFG2_RESET; // see R15
    end else if (wr_done & lanes_ok & (sel == MCRS_SEL_CFG2)) begin
      cfg2_q <= mcrs_apply(cfg2_q, wd_lo, alias_sel, MCRS_CFG2_MASK); // see R14
    end
  end

  // Receive results
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rx_frame_accept <= 1'b0;
      o_rx_pause_act <= 1'b0;
    end else begin
      o_rx_frame_accept <= rx_ok_evt;
      o_rx_pause_act <= rx_ok_evt & i_rx_is_pause & cfg1_q[MCRS_B_RX_FLOW_FRAME_HONOR]; // see R11
    end
  end

  // Pad length and CRC decision for the frame being presented
  assign pad_on = cfg2_q[MCRS_B_SHORT_FRAME_PAD_ON];
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_tx_pad_len <= MCRS_PAD_NONE;
      o_tx_crc_append <= 1'b0;
    end else if (tx_held) begin
      o_tx_pad_len <= MCRS_PAD_NONE;
      o_tx_crc_append <= 1'b0;
    end else if (i_tx_type_valid) begin
      o_tx_crc_append <= cfg2_q[MCRS_B_CRC_APPEND_ON]; // see R22
      if (!pad_on) begin
        o_tx_pad_len <= MCRS_PAD_NONE; // see R20 see R21
      end else if (cfg2_q[MCRS_B_PAD_TO_SIXTY_FOUR]) begin
        o_tx_pad_len <= MCRS_PAD_LONG; // see R20
      end else if (cfg2_q[MCRS_B_TAG_DETECT_PAD] & (i_tx_type_field == MCRS_VLAN_TPID)) begin
        o_tx_pad_len <= MCRS_PAD_LONG; // see R19
      end else begin
        o_tx_pad_len <= MCRS_PAD_SHORT; // see R23
      end
    end
  end

  // Backoff random generator
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_backoff_rand <= MCRS_RNG_SEED;
    end else if (cfg1_q[MCRS_B_BACKOFF_RNG_RESET] | tx_held) begin
      o_backoff_rand <= MCRS_RNG_SEED; // see R8
    end else begin
      o_backoff_rand <= {o_backoff_rand[8:0], ^(o_backoff_rand & MCRS_RNG_TAPS)};
    end
  end

  // Reset and mode controls
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_media_if_reset <= 1'b1;
      o_rx_ctrl_reset <= 1'b1;
      o_rx_func_reset <= 1'b1;
      o_tx_ctrl_reset <= 1'b1;
      o_tx_func_reset <= 1'b1;
      o_loopback <= 1'b0;
      o_tx_pause_allow <= 1'b0;
      o_unbounded_defer <= 1'b0;
      o_skip_backoff <= 1'b0;
      o_bp_skip_backoff <= 1'b0;
    end else begin
      o_media_if_reset <= cfg1_q[MCRS_B_WHOLE_MAC_RESET]; // see R7
      o_rx_ctrl_reset <= cfg1_q[MCRS_B_WHOLE_MAC_RESET]
                         | cfg1_q[MCRS_B_RX_CTRL_SUBLAYER_RESET]; // see R9
      o_rx_func_reset <= cfg1_q[MCRS_B_WHOLE_MAC_RESET] | cfg1_q[MCRS_B_RX_FUNCTION_RESET];
      o_tx_ctrl_reset <= cfg1_q[MCRS_B_WHOLE_MAC_RESET]
                         | cfg1_q[MCRS_B_TX_CTRL_SUBLAYER_RESET]; // see R9
      o_tx_func_reset <= tx_held; // see R9
      o_loopback <= cfg1_q[MCRS_B_LOOPBACK]; // see R10
      o_tx_pause_allow <= cfg1_q[MCRS_B_TX_FLOW_FRAME_ALLOW]; // see R11
      o_unbounded_defer <= cfg2_q[MCRS_B_UNBOUNDED_DEFER]; // see R15
      o_skip_backoff <= cfg2_q[MCRS_B_SKIP_BACKOFF]; // see R16
      o_bp_skip_backoff <= cfg2_q[MCRS_B_BACKPRESSURE_SKIP_BACKOFF]; // see R16
    end
  end

endmodule
`default_nettype wire

// [mcrs_assertions.sv]
// Port-level checks for the MAC config and receive statistics block
`timescale 1ns/1ns
`default_nettype none
module mcrs_assertions
  import mcrs_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  // Bus
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // Receive status
  input wire logic i_rx_frame_end,
  input wire logic i_rx_filter_ok,
  input wire logic i_rx_fcs_err,
  input wire logic i_rx_is_pause,
  input wire logic o_rx_frame_accept,
  input wire logic o_rx_pause_act,
  // Transmit
  input wire logic i_tx_type_valid,
  input wire logic [6:0] o_tx_pad_len,
  input wire logic [9:0] o_backoff_rand,
  // Reset outputs
  input wire logic o_media_if_reset,
  input wire logic o_rx_ctrl_reset,
  input wire logic o_rx_func_reset,
  input wire logic o_tx_ctrl_reset,
  input wire logic o_tx_func_reset
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  sequence s_setup;
    i_psel && !i_penable;
  endsequence
  sequence s_done;
    i_psel && i_penable && o_pready;
  endsequence
  sequence s_frame_held;
    i_rx_frame_end ##1 o_rx_func_reset;
  endsequence
  chk_ready_next: assert property (s_setup |=> s_done) else $error("no ready after setup");
  chk_ready_single: assert property (o_pready |=> !o_pready) else $error("ready too long");
  chk_upper_zero: assert property (o_pready |-> o_prdata[31:16] == 16'h0)
    else $error("upper read bits set");
  chk_error_unmapped: assert property (o_pready && o_pslverr |-> i_paddr > 8'h4F && o_prdata == 0)
    else $error("error on mapped address");
  chk_fcs_reject: assert property (i_rx_frame_end && i_rx_fcs_err |=> !o_rx_frame_accept)
    else $error("bad frame accepted");
  chk_accept_cause: assert property (o_rx_frame_accept |->
    $past(i_rx_frame_end && i_rx_filter_ok && !i_rx_fcs_err))
    else $error("accept without good frame");
  chk_rx_held: assert property (s_frame_held |-> !o_rx_frame_accept)
    else $error("accept while receive held");
  chk_pause_cause: assert property (o_rx_pause_act |-> o_rx_frame_accept && $past(i_rx_is_pause))
    else $error("pause act without pause frame");
  chk_soft_all: assert property (o_media_if_reset |-> o_rx_ctrl_reset && o_rx_func_reset &&
    o_tx_ctrl_reset && o_tx_func_reset) else $error("soft reset not global");
  chk_pad_cause: assert property ($changed(o_tx_pad_len) |->
    $past(i_tx_type_valid) || o_tx_func_reset) else $error("pad length moved alone");
  chk_pad_legal: assert property (o_tx_pad_len == MCRS_PAD_NONE || o_tx_pad_len == MCRS_PAD_SHORT
    || o_tx_pad_len == MCRS_PAD_LONG) else $error("illegal pad length");
  chk_rand_live: assert property (o_backoff_rand != 10'h0) else $error("backoff source stuck");
endmodule
bind mcrs_mac_config_and_rx_error_stats mcrs_assertions chk_u (
  .i_clock(i_clock), .i_resetn(i_resetn), .i_psel(i_psel), .i_penable(i_penable),
  .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_rx_frame_end(i_rx_frame_end), .i_rx_filter_ok(i_rx_filter_ok),
  .i_rx_fcs_err(i_rx_fcs_err), .i_rx_is_pause(i_rx_is_pause),
  .o_rx_frame_accept(o_rx_frame_accept), .o_rx_pause_act(o_rx_pause_act),
  .i_tx_type_valid(i_tx_type_valid), .o_tx_pad_len(o_tx_pad_len), .o_backoff_rand(o_backoff_rand),
  .o_media_if_reset(o_media_if_reset), .o_rx_ctrl_reset(o_rx_ctrl_reset),
  .o_rx_func_reset(o_rx_func_reset), .o_tx_ctrl_reset(o_tx_ctrl_reset),
  .o_tx_func_reset(o_tx_func_reset)
);
`default_nettype wire

// [mcrs_phy_model.sv]
// Behavioural media side source of preamble bytes, frame status and type fields
`timescale 1ns/1ns
`default_nettype none
module mcrs_phy_model (
  // Clock
  input wire logic i_clock,
  // Preamble stream
  output logic o_pre_valid,
  output logic [7:0] o_pre_byte,
  output logic o_pre_err,
  // Frame end status
  output logic o_frame_end,
  output logic o_filter_ok,
  output logic o_fcs_err,
  output logic o_dribble,
  output logic o_is_control,
  output logic o_is_pause,
  // Transmit type field
  output logic o_type_valid,
  output logic [15:0] o_type_field
);
  initial begin
    {o_pre_valid, o_pre_err, o_frame_end, o_type_valid} = 4'h0;
    {o_filter_ok, o_fcs_err, o_dribble, o_is_control, o_is_pause} = 5'h0;
    o_pre_byte = 8'h0;
    o_type_field = 16'h0;
  end
  // Preamble of n bytes, last one b with error e, then status q at frame end
  task automatic frame(input int n, input logic [7:0] b, input logic e, input logic [4:0] q);
    repeat ($urandom % 3) @(posedge i_clock);
    for (int i = 0; i < n; i++) begin
      @(posedge i_clock);
      o_pre_valid <= 1'b1;
      o_pre_byte <= (i == n - 1) ? b : 8'h55;
      o_pre_err <= e && (i == n - 1);
    end
    @(posedge i_clock);
    o_pre_valid <= 1'b0;
    o_pre_byte <= ~o_pre_byte;
    o_frame_end <= 1'b1;
    {o_filter_ok, o_fcs_err, o_dribble, o_is_control, o_is_pause} <= q;
    @(posedge i_clock);
    o_frame_end <= 1'b0;
    {o_filter_ok, o_fcs_err, o_dribble, o_is_control, o_is_pause} <= ~q;
  endtask
  // Type octets after the source address of a transmit frame
  task automatic txtype(input logic [15:0] t);
    @(posedge i_clock);
    o_type_valid <= 1'b1;
    o_type_field <= t;
    @(posedge i_clock);
    o_type_valid <= 1'b0;
    o_type_field <= ~t;
  endtask
endmodule
`default_nettype wire

// [mac_config_and_rx_error_stats_bench.sv]
// Self-checking bench for the MAC config and receive statistics block
`timescale 1ns/1ns
`default_nettype none
module mac_config_and_rx_error_stats_bench
  import mcrs_pkg::*;
  ;
  logic clk, rstn, psel, penable, pwrite, pready, pslverr, acc;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic pre_v, pre_e, fend, fok, fcs, drib, ctl, pse, tyv, accept, pause_act, crc_app;
  logic mreset, rxc_r, rxf_r, txc_r, txf_r, loopb, txp, udef, skipb, bpskip;
  logic [7:0] pre_b;
  logic [15:0] tyf, c1, c2, d, ty, rq;
  logic [6:0] pad_len, ep;
  logic [9:0] rnd;
  logic [32:0] exp_q [$];
  int err_total, cmp_count, cyc, cnt [3];
  mcrs_mac_config_and_rx_error_stats dut_u (.i_clock(clk), .i_resetn(rstn), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_rx_pre_valid(pre_v),
    .i_rx_pre_byte(pre_b), .i_rx_pre_err(pre_e), .i_rx_frame_end(fend), .i_rx_filter_ok(fok),
    .i_rx_fcs_err(fcs), .i_rx_dribble(drib), .i_rx_is_control(ctl), .i_rx_is_pause(pse),
    .i_tx_type_valid(tyv), .i_tx_type_field(tyf), .o_rx_frame_accept(accept),
    .o_rx_pause_act(pause_act), .o_tx_pad_len(pad_len), .o_tx_crc_append(crc_app),
    .o_media_if_reset(mreset), .o_rx_ctrl_reset(rxc_r), .o_rx_func_reset(rxf_r),
    .o_tx_ctrl_reset(txc_r), .o_tx_func_reset(txf_r), .o_loopback(loopb), .o_tx_pause_allow(txp),
    .o_unbounded_defer(udef), .o_skip_backoff(skipb), .o_bp_skip_backoff(bpskip),
    .o_backoff_rand(rnd));
  mcrs_phy_model phy_u (.i_clock(clk), .o_pre_valid(pre_v), .o_pre_byte(pre_b), .o_pre_err(pre_e),
    .o_frame_end(fend), .o_filter_ok(fok), .o_fcs_err(fcs), .o_dribble(drib), .o_is_control(ctl),
    .o_is_pause(pse), .o_type_valid(tyv), .o_type_field(tyf));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      conclude();
    end
  end
  task automatic cmp_rd(input logic [32:0] g, input logic [32:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t read got %h want %h", $time, g, e);
    end
  endtask
  task automatic cmp_v(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t port got %h want %h", $time, g, e);
    end
  endtask
  always @(posedge clk) begin
    if (psel && penable && !pwrite && pready === 1'b1 && exp_q.size() > 0) begin
      cmp_rd({pslverr, prdata}, exp_q.pop_front());
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [3:0] s, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0, s);
  endtask
  task automatic send(input int n, input logic [7:0] b, input logic e, input logic [4:0] q);
    logic on;
    logic pre;
    on = !c1[15] && !c1[11] && !c1[10] && c1[0];
    pre = !(c2[9] && n >= 12) && !(c2[8] && (b !== 8'h55 || e));
    acc = on && q[4] && !q[3] && pre && (!q[1] || c1[1]);
    phy_u.frame(n, b, e, q);
    #1;
    cmp_v({15'h0, accept}, {15'h0, acc});
    cmp_v({15'h0, pause_act}, {15'h0, acc && q[0] && c1[2]});
    cnt[0] += int'(acc);
    cnt[1] += int'(on && q[3] && !q[2]);
    cnt[2] += int'(on && q[3] && q[2]);
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    rstn = 1'b0;
    cnt = '{0, 0, 0};
    void'($urandom(32'hDB9D0860));
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    c1 = 16'h800D;
    c2 = 16'h40B0;
    rd(8'h30, 4'hF, {17'h0, c1});
    rd(8'h40, 4'hF, {17'h0, c2});
    #1;
    cmp_v({12'h0, mreset, udef, txp, loopb}, 16'hE);
    send(7, 8'h55, 1'b0, 5'h10);
    apb(1'b1, 8'h38, 32'h8000, 4'hF);
    apb(1'b1, 8'h30, 32'hFFFF, 4'h1);
    apb(1'b1, 8'h30, 32'hFFFF, 4'hC);
    apb(1'b1, 8'h34, 32'h12, 4'h3);
    c1 = 16'h001F;
    rd(8'h30, 4'hF, {17'h0, c1});
    #1;
    cmp_v({14'h0, mreset, loopb}, 16'h1);
    for (int i = 0; i < 60; i++) begin
      if (i == 20 || i == 25) apb(1'b1, 8'h3C, 32'h1, 4'hF);
      if (i == 20 || i == 25) c1[0] = ~c1[0];
      if (i == 30) apb(1'b1, 8'h38, 32'h2, 4'hF);
      if (i == 30) c1[1] = 1'b0;
      if (i == 45) apb(1'b1, 8'h34, 32'hF00, 4'hF);
      if (i == 45) c1[11:8] = 4'hF;
      rq = 16'($urandom);
      send(7, 8'h55, 1'b0, {rq[4:1], rq[1]});
    end
    cmp_v({12'h0, rxc_r, rxf_r, txc_r, txf_r}, 16'hF);
    apb(1'b1, 8'h38, 32'hF00, 4'hF);
    c1[11:8] = 4'h0;
    for (int k = 0; k < 3; k++) begin
      rd(8'(16 * k), 4'hC, {17'h0, 16'(cnt[k])});
      rd(8'(16 * k), 4'hF, {17'h0, 16'(cnt[k])});
      rd(8'(16 * k + 4), 4'h3, 33'h0);
    end
    apb(1'b1, 8'h24, 32'h5, 4'h3);
    rd(8'h20, 4'hF, {17'h0, 16'h5});
    apb(1'b1, 8'h44, 32'h300, 4'hF);
    c2 = c2 | 16'h0300;
    send(12, 8'h55, 1'b0, 5'h10);
    send(11, 8'h55, 1'b0, 5'h10);
    send(7, 8'h54, 1'b0, 5'h10);
    send(7, 8'h55, 1'b1, 5'h10);
    apb(1'b1, 8'h48, 32'h300, 4'hF);
    c2 = c2 & 16'hFCFF;
    rd(8'h00, 4'hF, {17'h0, 16'h1});
    for (int k = 0; k < 16; k++) begin
      d = 16'h4000 | (16'(k) << 4) | (16'(k & 3) << 12);
      d[4] = d[4] | d[5];
      apb(1'b1, 8'h40, {16'h0, d}, 4'h3);
      c2 = d;
      for (int t = 0; t < 2; t++) begin
        ty = (t == 1) ? 16'h8100 : 16'h0800;
        phy_u.txtype(ty);
        #1;
        ep = !d[5] ? 7'h00 : (d[6] || (d[7] && ty == 16'h8100)) ? 7'h40 : 7'h3C;
        cmp_v({9'h0, pad_len}, {9'h0, ep});
        cmp_v({15'h0, crc_app}, {15'h0, d[4]});
      end
      cmp_v({14'h0, bpskip, skipb}, {14'h0, d[13:12]});
    end
    apb(1'b1, 8'h34, 32'h4000, 4'hF);
    repeat (2) @(posedge clk);
    #1;
    cmp_v({6'h0, rnd}, {6'h0, MCRS_RNG_SEED});
    apb(1'b1, 8'h38, 32'h4000, 4'hF);
    rd(8'h60, 4'hF, {1'b1, 32'h0});
    @(posedge clk);
    cmp_v(16'(exp_q.size()), 16'h0);
    conclude();
  end
endmodule
`default_nettype wire
